// *** logic/clkpm_pkg.sv ***
package clkpm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Source and mode encodings
	typedef enum logic [2:0] {
		MS_NONE,
		MS_OSC12,
		MS_OSCHF,
		MS_XTAL,
		MS_FIRST_PLL,
		MS_SECOND_PLL,
		MS_LP1M,
		MS_RTC
	} main_src_t;

	typedef enum logic [2:0] {
		RS_NONE,
		RS_OSC12,
		RS_XTAL,
		RS_LP1M,
		RS_RTC
	} ref_src_t;

	typedef enum logic [2:0] {
		CO_NONE,
		CO_MAIN,
		CO_FIRST_PLL,
		CO_SECOND_PLL,
		CO_OSC12,
		CO_LP1M,
		CO_RTC
	} mon_src_t;

	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_SLEEP,
		PM_DSLEEP,
		PM_PDOWN,
		PM_DPDOWN
	} pmode_t;

	typedef enum logic [1:0] {
		SW_RUN,
		SW_DROP,
		SW_ADD
	} sw_stage_t;

	////////////////////////////////////////////////////////////////////////////
	// Sizes and constants
	localparam int        MAIN_N    = 8;
	localparam int        SEL_W     = 3;
	localparam main_src_t MAIN_RST  = MS_OSC12;
	localparam int        HF_MHZ    = 96;
	localparam int        DIV_MHZ   = 12;
	localparam int        HF_DIV    = HF_MHZ / DIV_MHZ;
	localparam int        HF_DIV_W  = $clog2(HF_DIV);
	localparam int        CO_DIV_W  = 8;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic osc_high;
		logic lp1m;
		logic rtc_raw;
		logic xtal;
		logic bypass;
		logic first_pll;
		logic second_pll;
	} src_ticks_t;

	typedef struct packed {
		logic osc12;
		logic fro32k;
		logic lp1m;
		logic rtc_xtal;
		logic xtal;
	} osc_keep_t;

	localparam osc_keep_t OSC_ALL_ON = 5'h1F;
	localparam osc_keep_t OSC_ALL_OFF = 5'h00;

	typedef struct packed {
		logic pin_int;
		logic group_int;
		logic timer;
		logic rtc_alarm;
		logic wdt;
		logic brownout_detector;
		logic comm;
		logic cmp;
		logic plu;
	} wake_t;

	localparam int WAKE_W = $bits(wake_t);

endpackage

// *** logic/clk_switch.sv ***
`timescale 1ns/10ps
module clk_switch #(
	parameter int        N         = 8,
	parameter int        W         = 3,
	parameter logic [2:0] RESET_SEL = 3'h1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [N-1:0] tick_in,
	input  wire logic [W-1:0] sel,
	output logic              tick_out,
	output logic              busy
);
	import clkpm_pkg::*;

	typedef struct packed {
		logic [W-1:0] cur;
		logic [W-1:0] tgt;
		sw_stage_t    stage;
		logic         tick;
		logic         busy;
	} sw_st_t;

	sw_st_t st_r;
	sw_st_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Two-step handover
	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		unique case (st_r.stage)
			SW_RUN:
			begin
				st_nxt.tick = tick_in[st_r.cur];
				if (sel != st_r.cur)
				begin
					st_nxt.tgt   = sel;
					st_nxt.stage = SW_DROP;
				end
			end
			SW_DROP:
			begin
				st_nxt.tick = tick_in[st_r.cur];
				if (tick_in[st_r.cur])
					st_nxt.stage = SW_ADD;
			end
			SW_ADD:
			begin
				if (tick_in[st_r.tgt])
				begin
					st_nxt.cur   = st_r.tgt;
					st_nxt.stage = SW_RUN;
				end
			end
			default:
				st_nxt.stage = SW_RUN;
		endcase
		st_nxt.busy = (st_nxt.stage != SW_RUN);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r       <= '0;
			st_r.cur   <= RESET_SEL;
			st_r.stage <= SW_RUN;
		end
		else
			st_r <= st_nxt;
	end

	assign tick_out = st_r.tick;
	assign busy     = st_r.busy;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_drop_done;
		(st_r.stage == SW_DROP) && tick_in[st_r.cur];
	endsequence

	sequence s_add_done;
		(st_r.stage == SW_ADD) && tick_in[st_r.tgt];
	endsequence

	property p_reset_src;
		@(posedge clk) !resetn |=> (st_r.cur == RESET_SEL) && !busy;
	endproperty
	a_reset_src: assert property (p_reset_src) else $error("reset source wrong");

	property p_switch_start;
		@(posedge clk) disable iff (!resetn)
		(st_r.stage == SW_RUN) && (sel != st_r.cur) |=> busy && (st_r.stage == SW_DROP);
	endproperty
	a_switch_start: assert property (p_switch_start) else $error("switch not started");

	property p_gap;
		@(posedge clk) disable iff (!resetn)
		s_drop_done |=> (st_r.stage == SW_ADD) && tick_out ##1 !tick_out;
	endproperty
	a_gap: assert property (p_gap) else $error("old gate not dropped");

	property p_complete;
		@(posedge clk) disable iff (!resetn)
		s_add_done |=> (st_r.cur == $past(st_r.tgt)) && (st_r.stage == SW_RUN) && !busy;
	endproperty
	a_complete: assert property (p_complete) else $error("switch not completed");

endmodule // clk_switch

// *** logic/clk_pm_ctrl.sv ***
`timescale 1ns/10ps
// Operation
// - Main clock from 12 MHz source after reset
// - 96 MHz source, 12 MHz divided from it
// - Synchronized mux switches only between running sources
// - Output divider stops and restarts cleanly
// - PLL reference: 12M, crystal, 1M, RTC
// - Software enables each PLL; reference 2k-150M
// - PLL output selectable on monitor pin
// - RTC clock only after control enable
// - Every mux has a tied-off none input
// - Main clock drives CPU and bus
// - Crystal input accepts bypass clock up to 25M
// - Brown-out gives interrupt or reset
// - Sleep, deep-sleep, power-down, deep power-down modes
// - Sleep gates CPU clock until interrupt
// - Enabled peripherals run in sleep and wake
// - Deep-sleep: flash off, CPU off, peripherals gated
// - Deep-sleep keeps each oscillator by choice
// - Deep-sleep left on listed wake sources
// - DMA served in deep-sleep without waking
// - Deep-sleep retains state; RAM banks kept per RAM_RET_CFG
module clk_pm_ctrl #(
	parameter int PERIPH_N = 8,
	parameter int RAM_N    = 4
) (
	input  wire logic                     CLK,
	input  wire logic                     RESETN,
	input  wire clkpm_pkg::src_ticks_t    OSC_TICKS,
	input  wire logic                     XTAL_BYPASS,
	input  wire logic                     RTC_OSC_EN,
	input  wire clkpm_pkg::main_src_t     MAIN_SEL,
	input  wire clkpm_pkg::ref_src_t      FIRST_PLL_REF_SEL,
	input  wire clkpm_pkg::ref_src_t      SECOND_PLL_REF_SEL,
	input  wire logic                     FIRST_PLL_EN,
	input  wire logic                     SECOND_PLL_EN,
	input  wire clkpm_pkg::mon_src_t      MON_SEL,
	input  wire logic [clkpm_pkg::CO_DIV_W-1:0] MON_DIV,
	input  wire logic                     MON_HALT,
	input  wire logic                     BOD_BELOW,
	input  wire logic                     BOD_RESET_EN,
	input  wire clkpm_pkg::pmode_t        MODE_REQ,
	input  wire logic                     MODE_ENTER,
	input  wire logic                     IRQ_PENDING,
	input  wire clkpm_pkg::wake_t         WAKE_SRC,
	input  wire clkpm_pkg::wake_t         WAKE_EN,
	input  wire clkpm_pkg::osc_keep_t     DSLEEP_OSC_KEEP,
	input  wire logic [PERIPH_N-1:0]      PERIPH_CLK_EN,
	input  wire logic [PERIPH_N-1:0]      DSLEEP_KEEP,
	input  wire logic [PERIPH_N-1:0]      DMA_REQ,
	input  wire logic [RAM_N-1:0]         RAM_RET_CFG,
	output logic                          MAIN_TICK,
	output logic                          MAIN_BUSY,
	output logic                          CPU_TICK,
	output logic                          BUS_TICK,
	output logic [PERIPH_N-1:0]           PERIPH_TICK,
	output logic                          FIRST_PLL_REF_TICK,
	output logic                          SECOND_PLL_REF_TICK,
	output logic                          FIRST_PLL_PWR,
	output logic                          SECOND_PLL_PWR,
	output logic                          MON_PIN,
	output clkpm_pkg::osc_keep_t          OSC_EN,
	output logic                          FLASH_PD,
	output logic                          BOD_IRQ,
	output logic                          BOD_RESET,
	output clkpm_pkg::pmode_t             MODE,
	output logic [RAM_N-1:0]              RAM_RETAIN
);
	import clkpm_pkg::*;

	typedef struct packed {
		pmode_t                 mode;
		logic [HF_DIV_W-1:0]    div_cnt;
		logic                   cpu_tick;
		logic                   bus_tick;
		logic [PERIPH_N-1:0]    periph_tick;
		logic                   first_pll_ref;
		logic                   second_pll_ref;
		logic                   first_pll_pwr;
		logic                   second_pll_pwr;
		logic [CO_DIV_W-1:0]    co_cnt;
		logic                   co_pin;
		osc_keep_t              osc_en;
		logic                   flash_pd;
		logic                   bod_q;
		logic                   bod_irq;
		logic                   bod_rst;
		logic [RAM_N-1:0]       ram_ret;
	} st_t;

	st_t                 st_r;
	st_t                 st_nxt;
	logic [MAIN_N-1:0]   src_vec;
	logic                osc12_t;
	logic                oschf_t;
	logic                xtal_t;
	logic                lp1m_t;
	logic                rtc_t;
	logic                main_t;
	logic                main_busy;
	logic                wake_any;
	logic                dma_ok;
	logic                low_pwr;

	////////////////////////////////////////////////////////////////////////////
	// Source conditioning
	always_comb
	begin
		oschf_t = OSC_TICKS.osc_high & st_r.osc_en.osc12;
		osc12_t = oschf_t && (st_r.div_cnt == HF_DIV_W'(HF_DIV - 1));
		xtal_t  = (XTAL_BYPASS ? OSC_TICKS.bypass : OSC_TICKS.xtal)
		          & st_r.osc_en.xtal;
		lp1m_t  = OSC_TICKS.lp1m & st_r.osc_en.lp1m;
		rtc_t   = OSC_TICKS.rtc_raw & RTC_OSC_EN & st_r.osc_en.rtc_xtal;
	end

	always_comb
	begin
		src_vec           = '0;
		src_vec[MS_OSC12] = osc12_t;
		src_vec[MS_OSCHF] = oschf_t;
		src_vec[MS_XTAL]  = xtal_t;
		src_vec[MS_FIRST_PLL]  = OSC_TICKS.first_pll & st_r.first_pll_pwr;
		src_vec[MS_SECOND_PLL]  = OSC_TICKS.second_pll & st_r.second_pll_pwr;
		src_vec[MS_LP1M]  = lp1m_t;
		src_vec[MS_RTC]   = rtc_t;
	end

	////////////////////////////////////////////////////////////////////////////
	// Synchronized main clock selector
	clk_switch #(
		.N         (MAIN_N),
		.W         (SEL_W),
		.RESET_SEL (MAIN_RST)
	) u_main_sw (
		.clk      (CLK),
		.resetn   (RESETN),
		.tick_in  (src_vec),
		.sel      (MAIN_SEL),
		.tick_out (main_t),
		.busy     (main_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Plain selectors
	function automatic logic ref_pick(input ref_src_t s);
		logic t;
		t = 1'b0;
		unique case (s)
			RS_NONE:  t = 1'b0;
			RS_OSC12: t = osc12_t;
			RS_XTAL:  t = xtal_t;
			RS_LP1M:  t = lp1m_t;
			RS_RTC:   t = rtc_t;
			default:  t = 1'b0;
		endcase
		return t;
	endfunction

	function automatic logic mon_pick(input mon_src_t s);
		logic t;
		t = 1'b0;
		unique case (s)
			CO_NONE:  t = 1'b0;
			CO_MAIN:  t = main_t;
			CO_FIRST_PLL:  t = src_vec[MS_FIRST_PLL];
			CO_SECOND_PLL:  t = src_vec[MS_SECOND_PLL];
			CO_OSC12: t = osc12_t;
			CO_LP1M:  t = lp1m_t;
			CO_RTC:   t = rtc_t;
			default:  t = 1'b0;
		endcase
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Wake and mode conditions
	always_comb
	begin
		wake_any = |(WAKE_SRC & WAKE_EN) | st_r.bod_irq;
		dma_ok   = |(DMA_REQ & PERIPH_CLK_EN & DSLEEP_KEEP);
		low_pwr  = (st_r.mode == PM_DSLEEP) || (st_r.mode == PM_PDOWN)
		           || (st_r.mode == PM_DPDOWN);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		st_nxt = st_r;

		// High-speed to 12 MHz divider
		if (oschf_t)
		begin
			if (st_r.div_cnt == HF_DIV_W'(HF_DIV - 1))
				st_nxt.div_cnt = '0;
			else
				st_nxt.div_cnt = st_r.div_cnt + 1'b1;
		end

		// Power mode sequencing
		unique case (st_r.mode)
			PM_ACTIVE:
				if (MODE_ENTER)
					st_nxt.mode = MODE_REQ;
			PM_SLEEP:
				if (IRQ_PENDING)
					st_nxt.mode = PM_ACTIVE;
			PM_DSLEEP:
				if (wake_any)
					st_nxt.mode = PM_ACTIVE;
			PM_PDOWN:
				if (WAKE_SRC.pin_int || WAKE_SRC.group_int || WAKE_SRC.rtc_alarm
				    || WAKE_SRC.timer || WAKE_SRC.comm || WAKE_SRC.cmp)
					st_nxt.mode = PM_ACTIVE;
			PM_DPDOWN:
				if (WAKE_SRC.rtc_alarm || WAKE_SRC.pin_int || WAKE_SRC.timer)
					st_nxt.mode = PM_ACTIVE;
			default:
				st_nxt.mode = PM_ACTIVE;
		endcase

		// Clock gating of CPU, bus and peripherals
		st_nxt.cpu_tick = main_t && (st_r.mode == PM_ACTIVE);
		st_nxt.bus_tick = main_t && ((st_r.mode == PM_ACTIVE)
		                  || (st_r.mode == PM_DSLEEP && dma_ok));
		unique case (st_r.mode)
			PM_ACTIVE, PM_SLEEP:
				st_nxt.periph_tick = {PERIPH_N{main_t}} & PERIPH_CLK_EN;
			PM_DSLEEP:
				st_nxt.periph_tick = {PERIPH_N{main_t}} & PERIPH_CLK_EN
				                     & DSLEEP_KEEP;
			default:
				st_nxt.periph_tick = '0;
		endcase

		// Flash, oscillators and memory retention
		st_nxt.flash_pd = low_pwr;
		unique case (st_r.mode)
			PM_DSLEEP:
				st_nxt.osc_en = DSLEEP_OSC_KEEP;
			PM_PDOWN, PM_DPDOWN:
			begin
				st_nxt.osc_en          = OSC_ALL_OFF;
				st_nxt.osc_en.fro32k   = DSLEEP_OSC_KEEP.fro32k;
				st_nxt.osc_en.rtc_xtal = DSLEEP_OSC_KEEP.rtc_xtal;
			end
			default:
				st_nxt.osc_en = OSC_ALL_ON;
		endcase
		st_nxt.ram_ret = (st_r.mode == PM_DSLEEP) ? RAM_RET_CFG : '0;

		// PLL control and references
		st_nxt.first_pll_pwr = FIRST_PLL_EN;
		st_nxt.second_pll_pwr = SECOND_PLL_EN;
		st_nxt.first_pll_ref = FIRST_PLL_EN && ref_pick(FIRST_PLL_REF_SEL);
		st_nxt.second_pll_ref = SECOND_PLL_EN && ref_pick(SECOND_PLL_REF_SEL);

		// Monitor pin output divider
		if (MON_HALT)
		begin
			st_nxt.co_cnt = '0;
			st_nxt.co_pin = 1'b0;
		end
		else if (mon_pick(MON_SEL))
		begin
			if (st_r.co_cnt == MON_DIV)
			begin
				st_nxt.co_cnt = '0;
				st_nxt.co_pin = ~st_r.co_pin;
			end
			else
				st_nxt.co_cnt = st_r.co_cnt + 1'b1;
		end

		// Brown-out response
		st_nxt.bod_q   = BOD_BELOW;
		st_nxt.bod_irq = BOD_BELOW && !BOD_RESET_EN;
		st_nxt.bod_rst = BOD_BELOW && !st_r.bod_q && BOD_RESET_EN;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			st_r        <= '0;
			st_r.mode   <= PM_ACTIVE;
			st_r.osc_en <= OSC_ALL_ON;
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign MAIN_TICK     = main_t;
	assign MAIN_BUSY     = main_busy;
	assign CPU_TICK      = st_r.cpu_tick;
	assign BUS_TICK      = st_r.bus_tick;
	assign PERIPH_TICK   = st_r.periph_tick;
	assign FIRST_PLL_REF_TICK = st_r.first_pll_ref;
	assign SECOND_PLL_REF_TICK = st_r.second_pll_ref;
	assign FIRST_PLL_PWR      = st_r.first_pll_pwr;
	assign SECOND_PLL_PWR      = st_r.second_pll_pwr;
	assign MON_PIN       = st_r.co_pin;
	assign OSC_EN        = st_r.osc_en;
	assign FLASH_PD      = st_r.flash_pd;
	assign BOD_IRQ       = st_r.bod_irq;
	assign BOD_RESET     = st_r.bod_rst;
	assign MODE          = st_r.mode;
	assign RAM_RETAIN    = st_r.ram_ret;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_div12;
		@(posedge CLK) disable iff (!RESETN)
		osc12_t |-> oschf_t ##1 (st_r.div_cnt == '0);
	endproperty
	a_div12: assert property (p_div12) else $error("12 MHz tick misplaced");

	property p_rtc_gate;
		@(posedge CLK) disable iff (!RESETN)
		!RTC_OSC_EN |-> !src_vec[MS_RTC];
	endproperty
	a_rtc_gate: assert property (p_rtc_gate) else $error("RTC clock not gated");

	property p_sleep_cpu;
		@(posedge CLK) disable iff (!RESETN)
		(st_r.mode != PM_ACTIVE) |=> !CPU_TICK;
	endproperty
	a_sleep_cpu: assert property (p_sleep_cpu) else $error("CPU clock in low power");

	property p_sleep_periph;
		@(posedge CLK) disable iff (!RESETN)
		(st_r.mode == PM_SLEEP) && main_t && PERIPH_CLK_EN[0] |=> PERIPH_TICK[0];
	endproperty
	a_sleep_periph: assert property (p_sleep_periph) else $error("peripheral stalled");

	property p_dsleep_flash;
		@(posedge CLK) disable iff (!RESETN)
		(st_r.mode == PM_DSLEEP) |=> FLASH_PD && (OSC_EN == $past(DSLEEP_OSC_KEEP));
	endproperty
	a_dsleep_flash: assert property (p_dsleep_flash) else $error("deep-sleep entry wrong");

	property p_wake;
		@(posedge CLK) disable iff (!RESETN)
		(st_r.mode == PM_DSLEEP) && wake_any |=> (MODE == PM_ACTIVE) ##1 !FLASH_PD;
	endproperty
	a_wake: assert property (p_wake) else $error("deep-sleep wake missed");

	property p_dma;
		@(posedge CLK) disable iff (!RESETN)
		(st_r.mode == PM_DSLEEP) && dma_ok && main_t && !wake_any
		|=> BUS_TICK && (MODE == PM_DSLEEP);
	endproperty
	a_dma: assert property (p_dma) else $error("deep-sleep DMA not served");

	property p_bod;
		@(posedge CLK) disable iff (!RESETN)
		BOD_BELOW && !st_r.bod_q |=> (BOD_RESET == $past(BOD_RESET_EN))
		                            && (BOD_IRQ == !$past(BOD_RESET_EN));
	endproperty
	a_bod: assert property (p_bod) else $error("brown-out response wrong");

	property p_mon_halt;
		@(posedge CLK) disable iff (!RESETN)
		MON_HALT [*2] |-> !MON_PIN && (st_r.co_cnt == '0);
	endproperty
	a_mon_halt: assert property (p_mon_halt) else $error("monitor divider not halted");

	property p_pll_off;
		@(posedge CLK) disable iff (!RESETN)
		!FIRST_PLL_EN |=> !FIRST_PLL_PWR && !FIRST_PLL_REF_TICK;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("PLL not disabled");

endmodule // clk_pm_ctrl

// *** verif/clk_pm_ctrl_bench.sv ***
`timescale 1ns/10ps
module clk_pm_ctrl_bench;
	import clkpm_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic       clk          = 1'b0;
	logic       resetn       = 1'b0;
	logic [5:0] tcnt         = 6'h00;
	src_ticks_t ticks;
	logic       xtal_bypass  = 1'b0;
	logic       rtc_osc_en   = 1'b1;
	logic       first_pll_en      = 1'b1;
	logic       second_pll_en      = 1'b1;
	logic       mon_halt     = 1'b0;
	logic       bod_below    = 1'b0;
	logic       bod_reset_en = 1'b0;
	logic       mode_enter   = 1'b0;
	logic       irq_pending  = 1'b0;
	main_src_t  main_sel     = MS_OSC12;
	ref_src_t   first_pll_ref     = RS_NONE;
	ref_src_t   second_pll_ref     = RS_NONE;
	mon_src_t   mon_sel      = CO_NONE;
	logic [7:0] mon_div      = 8'h00;
	pmode_t     mode_req     = PM_ACTIVE;
	wake_t      wake_src     = 9'h000;
	wake_t      wake_en      = 9'h000;
	osc_keep_t  keep         = 5'h19;
	logic [7:0] periph_en    = 8'h03;
	logic [7:0] ds_keep      = 8'h02;
	logic [7:0] dma_req      = 8'h02;
	logic [3:0] ram_cfg      = 4'h5;
	logic       main_tick, main_busy, cpu_tick, bus_tick, mon_pin, mon_q;
	logic       first_pll_ref_tick, second_pll_ref_tick, first_pll_pwr, second_pll_pwr;
	logic       flash_pd, bod_irq, bod_reset, probe;
	logic [7:0] periph_tick;
	logic [3:0] ram_retain;
	osc_keep_t  osc_en;
	pmode_t     mode;
	int         psel, pcount, mismatches, cmp_count;
	int         exp_m [8] = '{0, 12, 96, 48, 16, 12, 24, 6};
	int         exp_r [5] = '{0, 12, 48, 24, 6};
	int         exp_c [7] = '{0, 12, 16, 12, 12, 24, 6};

	initial forever #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	// Source ticks, all periods divide 48
	always @(posedge clk) tcnt <= (tcnt == 6'h2F) ? 6'h00 : tcnt + 6'h01;
	assign ticks = {1'b1, tcnt[1:0] == 2'h0, tcnt[3:0] == 4'h0, tcnt[0] == 1'b0,
		tcnt % 6'h03 == 6'h00, tcnt % 6'h06 == 6'h00, tcnt[2:0] == 3'h0};

	////////////////////////////////////////////////////////////////////////////
	// Pulse counter on a selected output
	always_comb
	begin
		case (psel)
			0: probe = main_tick;
			1: probe = cpu_tick;
			2: probe = bus_tick;
			3: probe = periph_tick[0];
			4: probe = periph_tick[1];
			5: probe = first_pll_ref_tick;
			6: probe = second_pll_ref_tick;
			7: probe = mon_pin ^ mon_q;
			default: probe = bod_reset;
		endcase
	end
	always @(posedge clk) mon_q <= mon_pin;
	always @(negedge clk) if (probe === 1'b1) pcount = pcount + 1;

	clk_pm_ctrl dut_u (
		.CLK(clk), .RESETN(resetn), .OSC_TICKS(ticks), .XTAL_BYPASS(xtal_bypass),
		.RTC_OSC_EN(rtc_osc_en), .MAIN_SEL(main_sel), .FIRST_PLL_REF_SEL(first_pll_ref),
		.SECOND_PLL_REF_SEL(second_pll_ref), .FIRST_PLL_EN(first_pll_en), .SECOND_PLL_EN(second_pll_en),
		.MON_SEL(mon_sel), .MON_DIV(mon_div), .MON_HALT(mon_halt),
		.BOD_BELOW(bod_below), .BOD_RESET_EN(bod_reset_en), .MODE_REQ(mode_req),
		.MODE_ENTER(mode_enter), .IRQ_PENDING(irq_pending), .WAKE_SRC(wake_src),
		.WAKE_EN(wake_en), .DSLEEP_OSC_KEEP(keep), .PERIPH_CLK_EN(periph_en),
		.DSLEEP_KEEP(ds_keep), .DMA_REQ(dma_req), .RAM_RET_CFG(ram_cfg),
		.MAIN_TICK(main_tick), .MAIN_BUSY(main_busy), .CPU_TICK(cpu_tick),
		.BUS_TICK(bus_tick), .PERIPH_TICK(periph_tick), .FIRST_PLL_REF_TICK(first_pll_ref_tick),
		.SECOND_PLL_REF_TICK(second_pll_ref_tick), .FIRST_PLL_PWR(first_pll_pwr), .SECOND_PLL_PWR(second_pll_pwr),
		.MON_PIN(mon_pin), .OSC_EN(osc_en), .FLASH_PD(flash_pd), .BOD_IRQ(bod_irq),
		.BOD_RESET(bod_reset), .MODE(mode), .RAM_RETAIN(ram_retain)
	);

	////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic measure(input int s, input int exp);
		psel = s;
		cyc(4);
		pcount = 0;
		cyc(96);
		check(pcount, exp);
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		main_sel <= MS_OSC12;
		cyc(16);
		resetn <= 1'b1;
		cyc(1);
		#1;
		check(osc_en, OSC_ALL_ON);
		check(mode, PM_ACTIVE);
		check(main_busy, 1'b0);
		cyc(1);
	endtask

	task automatic settle;
		int k;
		k = 0;
		cyc(1);
		#1;
		check(main_busy, 1'b1);
		while (main_busy !== 1'b0 && k < 300)
		begin
			cyc(1);
			#1;
			k++;
		end
		check(main_busy, 1'b0);
		cyc(1);
	endtask

	task automatic enter(input pmode_t m);
		mode_req <= m;
		mode_enter <= 1'b1;
		cyc(1);
		mode_enter <= 1'b0;
		cyc(2);
		#1;
	endtask

	task automatic endt(input string s);
		$display("test %s finished", s);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Tests
	initial
	begin
		mismatches = 0;
		cmp_count = 0;
		psel = 0;
		pcount = 0;
		do_reset;
		measure(0, 12);
		endt("reset");
		for (int p = 0; p < 2; p++)
			for (int r = 0; r < 5; r++)
			begin
				if (p == 0) first_pll_ref <= ref_src_t'(r);
				else second_pll_ref <= ref_src_t'(r);
				measure(5 + p, exp_r[r]);
			end
		xtal_bypass <= 1'b1;
		first_pll_ref <= RS_XTAL;
		measure(5, 32);
		xtal_bypass <= 1'b0;
		rtc_osc_en <= 1'b0;
		first_pll_ref <= RS_RTC;
		measure(5, 0);
		rtc_osc_en <= 1'b1;
		first_pll_en <= 1'b0;
		second_pll_en <= 1'b0;
		measure(5, 0);
		check(first_pll_pwr, 1'b0);
		check(second_pll_pwr, 1'b0);
		first_pll_en <= 1'b1;
		second_pll_en <= 1'b1;
		measure(5, 6);
		check(first_pll_pwr, 1'b1);
		check(second_pll_pwr, 1'b1);
		endt("pll");
		for (int s = 0; s < 7; s++)
		begin
			mon_sel <= mon_src_t'(s);
			measure(7, exp_c[s]);
		end
		mon_sel <= CO_FIRST_PLL;
		measure(7, 16);
		mon_div <= 8'h01;
		measure(7, 8);
		mon_halt <= 1'b1;
		measure(7, 0);
		check(mon_pin, 1'b0);
		mon_halt <= 1'b0;
		mon_div <= 8'h00;
		measure(7, 16);
		endt("monitor");
		bod_below <= 1'b1;
		cyc(3);
		#1;
		check(bod_irq, 1'b1);
		cyc(1);
		bod_below <= 1'b0;
		bod_reset_en <= 1'b1;
		cyc(3);
		psel = 8;
		pcount = 0;
		bod_below <= 1'b1;
		cyc(6);
		#1;
		check(pcount, 1);
		check(bod_irq, 1'b0);
		cyc(1);
		bod_below <= 1'b0;
		bod_reset_en <= 1'b0;
		wake_en <= 9'h1FF;
		endt("brownout");
		for (int m = 1; m < 5; m++)
		begin
			enter(pmode_t'(m));
			check(mode, pmode_t'(m));
			if (m == 1) measure(1, 0);
			if (m == 1) measure(3, 12);
			if (m == 2)
			begin
				check(flash_pd, 1'b1);
				check(osc_en, keep);
				check(ram_retain, ram_cfg);
				measure(1, 0);
				measure(3, 0);
				measure(4, 12);
				measure(2, 12);
				enter(PM_SLEEP);
				check(mode, PM_DSLEEP);
			end
			cyc(1);
			irq_pending <= 1'b1;
			wake_src <= 9'h040;
			cyc(3);
			#1;
			check(mode, PM_ACTIVE);
			cyc(1);
			irq_pending <= 1'b0;
			wake_src <= 9'h000;
			cyc(2);
			#1;
			check(flash_pd, 1'b0);
			check(ram_retain, 4'h0);
			cyc(1);
		end
		wake_src <= 9'h1FF;
		for (int i = 0; i < 9; i++)
		begin
			wake_en <= 9'h000;
			enter(PM_DSLEEP);
			check(mode, PM_DSLEEP);
			cyc(1);
			wake_en <= 9'h001 << i;
			cyc(3);
			#1;
			check(mode, PM_ACTIVE);
			cyc(1);
		end
		wake_src <= 9'h000;
		endt("modes");
		for (int i = 2; i < 9; i++)
		begin
			main_sel <= main_src_t'((i == 8) ? 1 : i);
			settle;
			measure(0, exp_m[(i == 8) ? 1 : i]);
		end
		measure(1, 12);
		measure(2, 12);
		main_sel <= MS_NONE;
		cyc(60);
		#1;
		check(main_busy, 1'b1);
		measure(0, 0);
		endt("main select");
		do_reset;
		measure(0, 12);
		endt("second reset");
		conclude;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude;
	end
endmodule // clk_pm_ctrl_bench
